/* File: spr_defs.svh */
`ifndef SPR_DEFS_SVH
`define SPR_DEFS_SVH

// Select-mode field encodings
`define SPR_MODE_3WIRE 2'h0
`define SPR_MODE_MULTI 2'h1

// Control reset values
`define SPR_RST_PORT_EN 1'h0
`define SPR_RST_MASTER_EN 1'h0
`define SPR_RST_SELECT_MODE 2'h1

// Byte framing
`define SPR_LAST_BIT 3'h7
`define SPR_BIT_CNT_ZERO 3'h0

// Serial clock half period in system clocks while master
`define SPR_SCK_HALF_CYCLES 4

// Pin synchroniser reset levels {sck, nss, miso, mosi}
`define SPR_SYNC_RST 4'h4

`endif

/* File: spr_pkg.sv */
package spr_pkg;

  typedef struct packed {
    logic portEnable;
    logic masterEnable;
    logic [1:0] selectMode;
  } spr_ctrl_type;

  typedef enum logic [1:0] {
    SPR_IDLE = 2'b01,
    SPR_SHIFT = 2'b10
  } spr_mstate_type;

endpackage

/* File: spr_sync.sv */
`timescale 1ns/100ps
module spr_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_r;

  // Two stages per bit; only the second stage is visible
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= RST_VAL;
      synced <= RST_VAL;
    end
    else
    begin
      meta_r <= async;
      synced <= meta_r;
    end
  end

endmodule // spr_sync

/* File: spr_pin_roles.sv */
// Behaviour
// RQ1: Master drives the master-out line; slave takes it as input.
// RQ2: Master takes the slave-out line as input; slave drives it.
// RQ3: Bytes shift most significant bit first on both lines.
// RQ4: Master out line comes straight from shift register top bit.
// RQ5: Slave-out is high impedance when disabled or unselected 4-wire slave.
// RQ6: 3-wire slave drives slave-out from shift register top bit continuously.
// RQ7: Serial clock driven only as master, received as slave.
// RQ8: 4-wire slave ignores serial clock while select input is high.
// RQ9: Select mode 00 is 3-wire form, select function disabled.
// RQ10: 3-wire slave always counts itself selected.
// RQ11: Select mode 01 makes the select pin an input selecting the slave.
// RQ12: Master in mode 01 disables itself on a select falling edge.
// RQ13: Mode 1x drives select pin out at the low mode bit level.
// RQ14: Software uses mode 1x only when configured as master.
// RQ15: Select pin unmapped in 3-wire modes, mapped otherwise.
// RQ16: System keeps a 3-wire slave alone on its bus.
// RQ17: Select-edge disable clears master and port enables, sets mode fault.
// RQ18: 4-wire slave clears its bit counter on select falling edge.
// RQ19: External master lowers select two clocks before first clock edge.
// RQ20: Slave sets transfer complete and stores byte after eight bits.
// RQ21: Select and serial clock inputs are synchronised before use.
`timescale 1ns/100ps
`include "spr_defs.svh"
module spr_pin_roles import spr_pkg::*; #(
  parameter int HALF_PERIOD = `SPR_SCK_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrlWrite,
  input wire spr_ctrl_type ctrlWrData,
  output spr_ctrl_type ctrlState,
  input wire logic txWrite,
  input wire logic [7:0] txData,
  output logic txReady,
  output logic [7:0] rxData,
  output logic transferCompleteFlag,
  input wire logic transferCompleteClr,
  output logic modeFaultFlag,
  input wire logic modeFaultClr,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic nssIn,
  output logic nssOut,
  output logic nssOe,
  output logic nssMapped
);

  // Divider needs room for the synchroniser delay on the returning data
  if (HALF_PERIOD < 4 || HALF_PERIOD > 255)
  begin : g_chk
    $error("spr_pin_roles: HALF_PERIOD must be 4 to 255");
  end

  localparam logic [7:0] HALF_LAST = 8'(HALF_PERIOD - 1);

  spr_ctrl_type ctrl_r;
  spr_mstate_type mState_r;
  logic [3:0] pinSync;
  logic sckSync, nssSync, misoSync, mosiSync;
  logic sckPrev_r, nssPrev_r;
  logic sckRise, nssFall;
  logic isMaster, isSlave, slaveSel, slaveActive, fourWireSlave;
  logic faultEvent, txAccept;
  logic [7:0] halfCnt_r;
  logic sckLevel_r, sampleBit_r;
  logic halfTick, masterRise, masterFall, slaveShift, byteDone, newBit;
  logic [7:0] shiftReg_r;
  logic [2:0] bitCnt_r;
  logic [7:0] rxData_r;
  logic xferDone_r, modeFault_r;

  // RQ21: synchronise pin inputs
  spr_sync #(
    .WIDTH(4),
    .RST_VAL(`SPR_SYNC_RST)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async({sckIn, nssIn, misoIn, mosiIn}),
    .synced(pinSync)
  );

  assign sckSync = pinSync[3];
  assign nssSync = pinSync[2];
  assign misoSync = pinSync[1];
  assign mosiSync = pinSync[0];

  // Edge history taken from synchronised levels only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sckPrev_r <= 1'b0;
      nssPrev_r <= 1'b1;
    end
    else
    begin
      sckPrev_r <= sckSync;
      nssPrev_r <= nssSync;
    end
  end

  assign sckRise = sckSync & ~sckPrev_r;
  assign nssFall = nssPrev_r & ~nssSync;

  assign isMaster = ctrl_r.portEnable & ctrl_r.masterEnable;
  assign isSlave = ctrl_r.portEnable & ~ctrl_r.masterEnable;
  assign fourWireSlave = isSlave & (ctrl_r.selectMode == `SPR_MODE_MULTI);

  // RQ9 RQ10 RQ11: selection by mode
  assign slaveSel = (ctrl_r.selectMode == `SPR_MODE_3WIRE) |
                    ((ctrl_r.selectMode == `SPR_MODE_MULTI) & ~nssSync);
  // RQ8: clock ignored unless selected
  assign slaveActive = isSlave & slaveSel;

  // RQ12: multi-master select edge
  assign faultEvent = isMaster & (ctrl_r.selectMode == `SPR_MODE_MULTI) & nssFall;

  // Loading only between bytes keeps a byte in flight intact
  assign txReady = ctrl_r.portEnable & (mState_r == SPR_IDLE) & (bitCnt_r == `SPR_BIT_CNT_ZERO);
  assign txAccept = txWrite & txReady;

  // RQ17: fault clears both enables, wins over a software write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_r.portEnable <= `SPR_RST_PORT_EN;
      ctrl_r.masterEnable <= `SPR_RST_MASTER_EN;
      ctrl_r.selectMode <= `SPR_RST_SELECT_MODE;
    end
    else if (faultEvent)
    begin
      ctrl_r.portEnable <= 1'b0;
      ctrl_r.masterEnable <= 1'b0;
    end
    else if (ctrlWrite)
    begin
      ctrl_r <= ctrlWrData;
    end
  end

  // Master sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mState_r <= SPR_IDLE;
    end
    else
    begin
      unique case (mState_r)
        SPR_IDLE:
        begin
          if (txAccept && isMaster)
          begin
            mState_r <= SPR_SHIFT;
          end
        end
        SPR_SHIFT:
        begin
          if (!isMaster || byteDone)
          begin
            mState_r <= SPR_IDLE;
          end
        end
      endcase
    end
  end

  assign halfTick = (mState_r == SPR_SHIFT) & (halfCnt_r == HALF_LAST);
  assign masterRise = halfTick & ~sckLevel_r;
  assign masterFall = halfTick & sckLevel_r;

  always_ff @(posedge clk)
  begin
    if (rst || mState_r != SPR_SHIFT || halfTick)
    begin
      halfCnt_r <= 8'h00;
    end
    else
    begin
      halfCnt_r <= halfCnt_r + 8'h01;
    end
  end

  // RQ7: clock generated only in master shifting
  always_ff @(posedge clk)
  begin
    if (rst || mState_r != SPR_SHIFT)
    begin
      sckLevel_r <= 1'b0;
    end
    else if (halfTick)
    begin
      sckLevel_r <= ~sckLevel_r;
    end
  end

  // RQ2: master samples slave-out on rising clock
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sampleBit_r <= 1'b0;
    end
    else if (masterRise)
    begin
      sampleBit_r <= misoSync;
    end
  end

  assign slaveShift = slaveActive & sckRise;
  assign newBit = masterFall ? sampleBit_r : mosiSync;

  // RQ3: shift left, top bit leaves first
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      shiftReg_r <= 8'h00;
    end
    else if (txAccept)
    begin
      shiftReg_r <= txData;
    end
    else if (masterFall || slaveShift)
    begin
      shiftReg_r <= {shiftReg_r[6:0], newBit};
    end
  end

  // RQ18: select fall restarts the count; disable is the only 3-wire slave restart; a master dropping out mid-byte also restarts
  always_ff @(posedge clk)
  begin
    if (rst || !ctrl_r.portEnable)
    begin
      bitCnt_r <= `SPR_BIT_CNT_ZERO;
    end
    else if ((fourWireSlave && nssFall) || (mState_r == SPR_SHIFT && !isMaster))
    begin
      bitCnt_r <= `SPR_BIT_CNT_ZERO;
    end
    else if (masterFall || slaveShift)
    begin
      bitCnt_r <= bitCnt_r + 3'h1;
    end
  end

  assign byteDone = (masterFall | slaveShift) & (bitCnt_r == `SPR_LAST_BIT);

  // RQ20: eighth bit stores byte and flags completion
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxData_r <= 8'h00;
    end
    else if (byteDone)
    begin
      rxData_r <= {shiftReg_r[6:0], newBit};
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      xferDone_r <= 1'b0;
    end
    else if (byteDone)
    begin
      xferDone_r <= 1'b1;
    end
    else if (transferCompleteClr)
    begin
      xferDone_r <= 1'b0;
    end
  end

  // RQ17: mode fault flag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      modeFault_r <= 1'b0;
    end
    else if (faultEvent)
    begin
      modeFault_r <= 1'b1;
    end
    else if (modeFaultClr)
    begin
      modeFault_r <= 1'b0;
    end
  end

  assign ctrlState = ctrl_r;
  assign rxData = rxData_r;
  assign transferCompleteFlag = xferDone_r;
  assign modeFaultFlag = modeFault_r;

  // RQ1 RQ4: master-out from top bit
  assign mosiOut = shiftReg_r[7];
  assign mosiOe = isMaster;
  // RQ5 RQ6: slave-out only while selected
  assign misoOut = shiftReg_r[7];
  assign misoOe = slaveActive;
  assign sckOut = sckLevel_r;
  assign sckOe = isMaster;
  // RQ13: select pin as output
  assign nssOut = ctrl_r.selectMode[0];
  assign nssOe = ctrl_r.selectMode[1];
  // RQ15: crossbar mapping of select pin
  assign nssMapped = (ctrl_r.selectMode != `SPR_MODE_3WIRE);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_masterPins;
    isMaster |-> mosiOe && sckOe && !misoOe && mosiOut == shiftReg_r[7];
  endproperty
  a_masterPins: assert property (p_masterPins) else $error("master pin roles wrong"); // RQ1

  property p_disabledQuiet;
    !ctrl_r.portEnable |-> !misoOe && !mosiOe && !sckOe;
  endproperty
  a_disabledQuiet: assert property (p_disabledQuiet) else $error("pins driven while off"); // RQ5

  property p_unselQuiet;
    fourWireSlave && nssSync |-> !misoOe;
  endproperty
  a_unselQuiet: assert property (p_unselQuiet) else $error("unselected slave drives"); // RQ5

  property p_threeWireSlave;
    isSlave && ctrl_r.selectMode == `SPR_MODE_3WIRE |-> misoOe && misoOut == shiftReg_r[7];
  endproperty
  a_threeWireSlave: assert property (p_threeWireSlave) else $error("3-wire slave silent"); // RQ6

  property p_sckIgnored;
    fourWireSlave && nssSync && !txAccept |=> $stable(bitCnt_r) && $stable(shiftReg_r);
  endproperty
  a_sckIgnored: assert property (p_sckIgnored) else $error("clock used while deselected"); // RQ8

  property p_nssDrive;
    ctrl_r.selectMode[1] |-> nssOe && nssOut == ctrl_r.selectMode[0] && nssMapped;
  endproperty
  a_nssDrive: assert property (p_nssDrive) else $error("select output level wrong"); // RQ13

  sequence s_nssEdge;
    isMaster && ctrl_r.selectMode == `SPR_MODE_MULTI && nssFall;
  endsequence
  sequence s_disabled;
    !ctrl_r.masterEnable && !ctrl_r.portEnable && modeFault_r;
  endsequence
  property p_modeFault;
    s_nssEdge |=> s_disabled;
  endproperty
  a_modeFault: assert property (p_modeFault) else $error("select edge did not disable"); // RQ17

  property p_countClear;
    fourWireSlave && nssFall |=> bitCnt_r == `SPR_BIT_CNT_ZERO;
  endproperty
  a_countClear: assert property (p_countClear) else $error("bit count not cleared"); // RQ18

  property p_slaveByte;
    slaveShift && bitCnt_r == `SPR_LAST_BIT |=>
      xferDone_r && bitCnt_r == `SPR_BIT_CNT_ZERO &&
      rxData_r == {$past(shiftReg_r[6:0]), $past(mosiSync)};
  endproperty
  a_slaveByte: assert property (p_slaveByte) else $error("slave byte not stored"); // RQ20

  sequence s_masterStart;
    txAccept && isMaster;
  endsequence
  property p_masterByte;
    s_masterStart ##1 isMaster [*8] |-> ##[1:200] (xferDone_r || !isMaster);
  endproperty
  a_masterByte: assert property (p_masterByte) else $error("master byte never ended"); // RQ3

endmodule // spr_pin_roles

/* File: spr_far_end.sv */
`timescale 1ns/100ps
module spr_far_end (
  input wire logic sckLine,
  input wire logic mosiLine,
  input wire logic misoLine,
  output logic misoDrv,
  output logic sckDrv,
  output logic mosiDrv,
  output logic nssDrv
);
  logic [7:0] slvSh = 8'h00;
  logic inBit = 1'h0;
  initial sckDrv = 1'h0;
  initial mosiDrv = 1'h0;
  // Select released high by default
  initial nssDrv = 1'h1;
  always @(posedge sckLine) inBit <= mosiLine;
  always @(negedge sckLine) slvSh <= {slvSh[6:0], inBit};
  assign misoDrv = slvSh[7];
  task automatic mxfer(input logic [7:0] d, input int n, output logic [7:0] got);
    got = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      mosiDrv = d[i];
      #160;
      sckDrv = 1'h1;
      got = {got[6:0], misoLine};
      #160;
      sckDrv = 1'h0;
    end
    // Clock stands still; data shows the inverse so stale bits never match
    mosiDrv = ~mosiDrv;
  endtask
endmodule // spr_far_end

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench import spr_pkg::*; ();
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ctrlWrite = 1'h0;
  logic txWrite = 1'h0;
  logic transferCompleteClr = 1'h0;
  logic modeFaultClr = 1'h0;
  logic tcSeen = 1'h0;
  logic [7:0] txData = 8'h00;
  logic [7:0] lfsr = 8'h03;
  logic [7:0] a, b, got, rxData;
  logic [7:0] expQ[$];
  spr_ctrl_type ctrlWrData = 4'h0;
  spr_ctrl_type ctrlState;
  logic txReady, transferCompleteFlag, modeFaultFlag, mosiOut, mosiOe, misoOut, misoOe;
  logic sckOut, sckOe, nssOut, nssOe, nssMapped, misoDrv, sckDrv, mosiDrv, nssDrv;
  logic mosiIn, misoIn, sckIn, nssIn;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  assign mosiIn = mosiOe ? mosiOut : mosiDrv;
  assign misoIn = misoOe ? misoOut : misoDrv;
  assign sckIn = sckOe ? sckOut : sckDrv;
  assign nssIn = nssOe ? nssOut : nssDrv;
  spr_pin_roles DUT (.clk, .rst, .ctrlWrite, .ctrlWrData, .ctrlState, .txWrite, .txData,
    .txReady, .rxData, .transferCompleteFlag, .transferCompleteClr, .modeFaultFlag,
    .modeFaultClr, .mosiIn, .mosiOut, .mosiOe, .misoIn, .misoOut, .misoOe, .sckIn, .sckOut,
    .sckOe, .nssIn, .nssOut, .nssOe, .nssMapped);
  spr_far_end far (.sckLine(sckIn), .mosiLine(mosiIn), .misoLine(misoIn), .misoDrv,
    .sckDrv, .mosiDrv, .nssDrv);
  always #20 clk = ~clk;
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      $display("MISMATCH %0t %s", $time, m);
      error_cnt++;
    end
  endtask
  // Monitor pairs each finished byte with the oldest note
  always @(posedge clk)
  begin
    tcSeen <= transferCompleteFlag;
    if (transferCompleteFlag === 1'b1 && tcSeen !== 1'b1)
    begin
      chk(expQ.size() > 0, "unexpected byte");
      if (expQ.size() > 0)
        chk(rxData === expQ.pop_front(), "rx byte");
    end
  end
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rnd();
    lfsr = nxt(lfsr);
    a = lfsr;
    lfsr = nxt(lfsr);
    b = lfsr;
  endtask
  task automatic setCtrl(input logic pe, input logic me, input logic [1:0] md);
    ctrlWrData = '{pe, me, md};
    ctrlWrite = 1'h1;
    tick();
    ctrlWrite = 1'h0;
    tick();
  endtask
  task automatic load(input logic [7:0] d);
    for (int i = 0; i < 50 && txReady !== 1'b1; i++)
      tick();
    chk(txReady === 1'b1, "not ready");
    txData = d;
    txWrite = 1'h1;
    tick();
    txWrite = 1'h0;
    tick();
  endtask
  task automatic waitTc();
    for (int i = 0; i < 400 && transferCompleteFlag !== 1'b1; i++)
      tick();
    chk(transferCompleteFlag === 1'b1, "no completion");
    transferCompleteClr = 1'h1;
    tick();
    transferCompleteClr = 1'h0;
    tick();
  endtask
  initial
  begin
    tick(12);
    rst = 1'h0;
    tick(3);
    chk(ctrlState === 4'h1 && misoOe === 1'b0 && nssMapped === 1'b1, "reset");
    setCtrl(1'h1, 1'h1, 2'h0);
    chk(mosiOe === 1'b1 && sckOe === 1'b1 && misoOe === 1'b0, "master pins");
    chk(nssOe === 1'b0 && nssMapped === 1'b0, "3-wire select");
    repeat (2)
    begin
      rnd();
      far.slvSh = b;
      expQ.push_back(b);
      load(a);
      chk(mosiOut === a[7], "master top bit");
      waitTc();
      chk(far.slvSh === a, "far slave byte");
    end
    for (int m = 2; m < 4; m++)
    begin
      setCtrl(1'h1, 1'h1, 2'(m));
      chk(nssOe === 1'b1 && nssOut === 1'(m) && nssMapped === 1'b1, "select out");
    end
    setCtrl(1'h1, 1'h1, 2'h1);
    chk(nssOe === 1'b0 && nssMapped === 1'b1, "select in");
    far.nssDrv = 1'h0;
    for (int i = 0; i < 10 && modeFaultFlag !== 1'b1; i++)
      tick();
    chk(modeFaultFlag === 1'b1 && ctrlState === 4'h1 && sckOe === 1'b0, "fault");
    far.nssDrv = 1'h1;
    modeFaultClr = 1'h1;
    tick();
    modeFaultClr = 1'h0;
    tick();
    chk(modeFaultFlag === 1'b0, "fault clear");
    setCtrl(1'h1, 1'h0, 2'h1);
    chk(misoOe === 1'b0 && mosiOe === 1'b0 && sckOe === 1'b0, "unselected");
    far.mxfer(8'hff, 8, got);
    tick(8);
    chk(transferCompleteFlag === 1'b0, "clock ignored");
    rnd();
    load(a);
    far.nssDrv = 1'h0;
    tick(4);
    chk(misoOe === 1'b1 && misoOut === a[7], "selected");
    far.mxfer(b, 3, got);
    far.nssDrv = 1'h1;
    tick(6);
    far.nssDrv = 1'h0;
    tick(4);
    // Partial byte must be forgotten after the select edge
    load(a);
    expQ.push_back(b);
    far.mxfer(b, 8, got);
    waitTc();
    chk(got === a, "slave out byte");
    far.nssDrv = 1'h1;
    setCtrl(1'h1, 1'h0, 2'h0);
    chk(misoOe === 1'b1 && nssMapped === 1'b0, "3-wire slave");
    rnd();
    load(a);
    chk(misoOut === a[7], "3-wire top bit");
    expQ.push_back(b);
    far.mxfer(b, 8, got);
    waitTc();
    chk(got === a, "3-wire byte");
    setCtrl(1'h0, 1'h0, 2'h1);
    chk(misoOe === 1'b0 && expQ.size() == 0, "disabled");
    end_sim();
  end
endmodule // testbench
